// ===== hw/rcrs_pkg.sv
// Package for the run command and reference select block
package rcrs_pkg;

    // ************************************************************
    // Source, mode and function codes
    // ************************************************************
    localparam logic [1:0] SRC_KEYPAD   = 2'h0;
    localparam logic [1:0] SRC_TERMINAL = 2'h1;
    localparam logic [1:0] SRC_COMM     = 2'h2;

    localparam logic [1:0] TM_TWO_ONE   = 2'h0;
    localparam logic [1:0] TM_TWO_TWO   = 2'h1;
    localparam logic [1:0] TM_THREE_ONE = 2'h2;
    localparam logic [1:0] TM_THREE_TWO = 2'h3;

    localparam logic [6:0] FN_FORWARD   = 7'h01;
    localparam logic [6:0] FN_REVERSE   = 7'h02;
    localparam logic [6:0] FN_THREE_EN  = 7'h03;
    localparam logic [6:0] FN_JOG_FWD   = 7'h04;
    localparam logic [6:0] FN_JOG_REV   = 7'h05;
    localparam logic [6:0] FN_COAST     = 7'h06;
    localparam logic [6:0] FN_RESET_FLT = 7'h07;
    localparam logic [6:0] FN_UP        = 7'h0a;
    localparam logic [6:0] FN_DOWN      = 7'h0b;
    localparam logic [6:0] FN_SWAP_AB   = 7'h0d;
    localparam logic [6:0] FN_COMB_TO_A = 7'h0e;
    localparam logic [6:0] FN_COMB_TO_B = 7'h0f;

    localparam logic [2:0] CM_A    = 3'h0;
    localparam logic [2:0] CM_B    = 3'h1;
    localparam logic [2:0] CM_SUM  = 3'h2;
    localparam logic [2:0] CM_DIFF = 3'h3;
    localparam logic [2:0] CM_MAX  = 3'h4;
    localparam logic [2:0] CM_MIN  = 3'h5;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ        = 125;
    localparam int DEBOUNCE_US    = 10;
    localparam int DEBOUNCE_TICKS = DEBOUNCE_US * CLK_MHZ;

    // Decoded terminal functions
    typedef struct packed {
        logic forward_input;
        logic reverse_input;
        logic threeEn;
        logic jogFwd;
        logic jogRev;
        logic coast;
        logic resetFault;
        logic up;
        logic down;
        logic swapAb;
        logic combToA;
        logic combToB;
    } rcrs_func_type;

    // Run command leaving the block
    typedef struct packed {
        logic run;
        logic reverse;
        logic jog;
        logic decelStop;
        logic coastStop;
        logic faultReset;
    } rcrs_cmd_type;

endpackage

// ===== hw/rcrs_top.sv
// Run command source select, terminal decode and frequency reference combine
// Notes on behaviour
// - Run source select: 0 keypad, 1 terminals, 2 communication; default 0.
// - Keypad run key starts and lights indicator; stop key stops, indicator off.
// - Input function codes: 1 fwd, 2 rev, 3 three-wire, 4/5 jog, 6 coast, 7 reset.
// - Terminal mode select: two-wire one/two, three-wire one/two; default 0.
// - Two-wire one: off/off stop, fwd only forward, rev only reverse, both hold.
// - Two-wire two: forward input enables, reverse input picks direction.
// - Three-wire one: forward edge starts in reverse level direction; reverse toggles.
// - Three-wire two: forward edge runs forward, reverse edge runs reverse.
// - Three-wire modes decelerate to stop when enable input opens.
// - Two-wire: after a foreign stop, terminal must be re-triggered to run.
// - Communication source takes start and stop from Modbus written values.
// - Effective reference is main reference plus up/down accumulated adjustment.
// - Functions 10 and 11 raise or lower reference at set rates while closed.
// - Combine mode: A, B, A+B, A-B, max, min; default 0.
// - Main reference may switch between A and B while running.
// - Function 13 swaps A and B in combine modes A and B only; 14 and 15 force combined to A or B.
`timescale 1ns/1ps
`default_nettype none
module rcrs_top
    import rcrs_pkg::*;
#(
    parameter int NUM_INPUTS = 9,
    parameter int REF_WIDTH  = 16,
    parameter int DEB_TICKS  = DEBOUNCE_TICKS
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [1:0]                    runSourceSelect,
    input  wire logic [1:0]                    terminalModeSelect,
    input  wire logic [2:0]                    referenceCombineMode,
    input  wire logic [NUM_INPUTS*7-1:0]       inputFunctionSelect,
    input  wire logic [NUM_INPUTS-1:0]         digitalInputs,
    input  wire logic                          runKey,
    input  wire logic                          stopResetKey,
    input  wire logic                          commStart,
    input  wire logic                          commStop,
    input  wire logic                          commReverse,
    input  wire logic                          otherStop,
    input  wire logic signed [REF_WIDTH-1:0]   channelA,
    input  wire logic signed [REF_WIDTH-1:0]   channelB,
    input  wire logic [REF_WIDTH-1:0]          upRateSetting,
    input  wire logic [REF_WIDTH-1:0]          downRateSetting,
    output var  logic                          runIndicator,
    output var  rcrs_cmd_type                  runCommand,
    output var  logic signed [REF_WIDTH-1:0]   effectiveReference
);

    // ************************************************************
    // Terminal conditioning
    // ************************************************************
    logic [NUM_INPUTS-1:0] syncA_reg;
    logic [NUM_INPUTS-1:0] syncB_reg;
    logic [NUM_INPUTS-1:0] stable_reg;
    logic [15:0]           debCount_reg [NUM_INPUTS];

    // Two flops then a hold-off counter; bounce shorter than DEB_TICKS is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= digitalInputs;
            syncB_reg <= syncA_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : gDeb
            // Level accepted only after staying put for the full window
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    debCount_reg[gi] <= '0;
                    stable_reg[gi]   <= 1'b0;
                end else if (syncB_reg[gi] == stable_reg[gi]) begin
                    debCount_reg[gi] <= '0;
                end else if (debCount_reg[gi] >= 16'(DEB_TICKS - 1)) begin
                    debCount_reg[gi] <= '0;
                    stable_reg[gi]   <= syncB_reg[gi];
                end else begin
                    debCount_reg[gi] <= debCount_reg[gi] + 16'h0001;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Function decode
    // ************************************************************
    rcrs_func_type func;

    // OR of every input holding each function code
    always_comb begin
        func = '0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (stable_reg[i]) begin
                unique case (inputFunctionSelect[i*7 +: 7])
                    FN_FORWARD:   func.forward_input        = 1'b1;
                    FN_REVERSE:   func.reverse_input        = 1'b1;
                    FN_THREE_EN:  func.threeEn    = 1'b1;
                    FN_JOG_FWD:   func.jogFwd     = 1'b1;
                    FN_JOG_REV:   func.jogRev     = 1'b1;
                    FN_COAST:     func.coast      = 1'b1;
                    FN_RESET_FLT: func.resetFault = 1'b1;
                    FN_UP:        func.up         = 1'b1;
                    FN_DOWN:      func.down       = 1'b1;
                    FN_SWAP_AB:   func.swapAb     = 1'b1;
                    FN_COMB_TO_A: func.combToA    = 1'b1;
                    FN_COMB_TO_B: func.combToB    = 1'b1;
                    default:      ;
                endcase
            end
        end
    end

    logic fwdPrev_reg;
    logic revPrev_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fwdPrev_reg <= 1'b0;
            revPrev_reg <= 1'b0;
        end else begin
            fwdPrev_reg <= func.forward_input;
            revPrev_reg <= func.reverse_input;
        end
    end
    logic fwdRise;
    logic revRise;
    logic revToggle;
    assign fwdRise   = func.forward_input & ~fwdPrev_reg;
    assign revRise   = func.reverse_input & ~revPrev_reg;
    assign revToggle = func.reverse_input ^ revPrev_reg;

    // ************************************************************
    // Run state
    // ************************************************************
    logic running_reg;
    logic reverse_reg;
    logic blocked_reg;
    logic running_next;
    logic reverse_next;
    logic blocked_next;
    logic decel_next;

    // Blocked flag keeps a foreign stop from being undone by a held terminal
    always_comb begin
        logic want;
        logic dir;
        want         = 1'b0;
        dir          = reverse_reg;
        running_next = running_reg;
        reverse_next = reverse_reg;
        blocked_next = blocked_reg;
        decel_next   = 1'b0;
        unique case (runSourceSelect)
            SRC_KEYPAD: begin
                if (runKey) begin
                    running_next = 1'b1;
                end else if (stopResetKey && running_reg) begin
                    running_next = 1'b0;
                end
            end
            SRC_TERMINAL: begin
                unique case (terminalModeSelect)
                    TM_TWO_ONE, TM_TWO_TWO: begin
                        if (terminalModeSelect == TM_TWO_ONE) begin
                            // Both closed holds the present state
                            if (func.forward_input ^ func.reverse_input) begin
                                want = 1'b1;
                                dir  = func.reverse_input;
                            end else if (func.forward_input) begin
                                want = running_reg;
                            end
                        end else begin
                            want = func.forward_input;
                            dir  = func.reverse_input;
                        end
                        if (!func.forward_input && !func.reverse_input) begin
                            blocked_next = 1'b0;
                        end
                        if (otherStop || func.coast) begin
                            running_next = 1'b0;
                            blocked_next = func.forward_input | func.reverse_input;
                        end else if (!blocked_reg) begin
                            running_next = want;
                            reverse_next = dir;
                        end
                    end
                    default: begin
                        if (!func.threeEn || otherStop || func.coast) begin
                            running_next = 1'b0;
                            decel_next   = ~func.threeEn & running_reg;
                        end else if (terminalModeSelect == TM_THREE_ONE) begin
                            if (fwdRise && !running_reg) begin
                                running_next = 1'b1;
                                reverse_next = func.reverse_input;
                            end else if (running_reg && revToggle) begin
                                reverse_next = ~reverse_reg;
                            end
                        end else begin
                            if (fwdRise) begin
                                running_next = 1'b1;
                                reverse_next = 1'b0;
                            end else if (revRise) begin
                                running_next = 1'b1;
                                reverse_next = 1'b1;
                            end
                        end
                    end
                endcase
            end
            default: begin
                if (commStop) begin
                    running_next = 1'b0;
                end else if (commStart) begin
                    running_next = 1'b1;
                    reverse_next = commReverse;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running_reg  <= 1'b0;
            reverse_reg  <= 1'b0;
            blocked_reg  <= 1'b0;
            runIndicator <= 1'b0;
            runCommand   <= '0;
        end else begin
            running_reg  <= running_next;
            reverse_reg  <= reverse_next;
            blocked_reg  <= blocked_next;
            runIndicator <= running_next;
            runCommand.run        <= running_next;
            runCommand.reverse    <= reverse_next;
            runCommand.jog        <= (runSourceSelect == SRC_TERMINAL)
                                   & (func.jogFwd | func.jogRev) & ~running_next;
            runCommand.decelStop  <= decel_next;
            runCommand.coastStop  <= (runSourceSelect == SRC_TERMINAL) & func.coast;
            runCommand.faultReset <= func.resetFault;
        end
    end

    // ************************************************************
    // Frequency reference
    // ************************************************************
    logic signed [REF_WIDTH-1:0] mainRef;
    logic signed [REF_WIDTH-1:0] updown_reg;

    // Combine and override are combinational, so switching needs no stop
    always_comb begin
        if (referenceCombineMode == CM_A) begin
            mainRef = func.swapAb ? channelB : channelA;
        end else if (referenceCombineMode == CM_B) begin
            mainRef = func.swapAb ? channelA : channelB;
        end else if (func.combToA) begin
            mainRef = channelA;
        end else if (func.combToB) begin
            mainRef = channelB;
        end else begin
            unique case (referenceCombineMode)
                CM_SUM:  mainRef = channelA + channelB;
                CM_DIFF: mainRef = channelA - channelB;
                CM_MAX:  mainRef = (channelA > channelB) ? channelA : channelB;
                default: mainRef = (channelA < channelB) ? channelA : channelB;
            endcase
        end
    end

    // Up/down offset ramps per clock while a terminal is closed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            updown_reg <= '0;
        end else if (func.up && !func.down) begin
            updown_reg <= updown_reg + $signed(upRateSetting);
        end else if (func.down && !func.up) begin
            updown_reg <= updown_reg - $signed(downRateSetting);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            effectiveReference <= '0;
        end else begin
            effectiveReference <= mainRef + updown_reg;
        end
    end

endmodule
`default_nettype wire

// ===== tb/rcrs_chk.sv
// Port checker for the run command and reference select block
`timescale 1ns/1ps
`default_nettype none
module rcrs_chk
    import rcrs_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic [1:0]   runSourceSelect,
    input wire logic [1:0]   terminalModeSelect,
    input wire logic         runKey,
    input wire logic         stopResetKey,
    input wire logic         commStart,
    input wire logic         commStop,
    input wire logic         commReverse,
    input wire logic         otherStop,
    input wire logic         runIndicator,
    input wire rcrs_cmd_type runCommand
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ************************************************************
    // Run command checks
    // ************************************************************
    reset_clear_a: assert property ($fell(rst) |-> !runIndicator && runCommand == '0)
        else $error("outputs not clear after reset");
    key_start_a: assert property (runSourceSelect == SRC_KEYPAD && runKey
        |=> runIndicator && runCommand.run) else $error("run key ignored");
    key_stop_a: assert property (runSourceSelect == SRC_KEYPAD && stopResetKey && !runKey
        |=> !runIndicator && !runCommand.run) else $error("stop key ignored");
    key_idle_a: assert property (runSourceSelect == SRC_KEYPAD && !runKey ##1
        runSourceSelect == SRC_KEYPAD |-> !$rose(runCommand.run)) else $error("start without key");
    comm_start_a: assert property (runSourceSelect == SRC_COMM && commStart && !commStop
        |=> runCommand.run && runCommand.reverse == $past(commReverse))
        else $error("comm start wrong");
    comm_stop_a: assert property (runSourceSelect == SRC_COMM && commStop |=> !runCommand.run)
        else $error("comm stop ignored");
    other_stop_a: assert property (runSourceSelect == SRC_TERMINAL && terminalModeSelect < 2
        && otherStop |=> !runCommand.run [*4]) else $error("restart after foreign stop");
    decel_pulse_a: assert property ($rose(runCommand.decelStop) |=> !runCommand.decelStop)
        else $error("decel stop not a pulse");
    decel_run_a: assert property (runCommand.decelStop |-> !runCommand.run)
        else $error("running while decelerating");
endmodule
`default_nettype wire

// ===== tb/rcrs_partner.sv
// Switch contact model driving the terminal inputs, with one bounce per change
`timescale 1ns/1ps
`default_nettype none
module rcrs_partner
(
    input  wire logic       clk,
    input  wire logic [8:0] target,
    output logic      [8:0] digitalInputs
);
    logic [8:0] settledReg;
    logic [8:0] maskReg;
    logic [1:0] cntReg;

    // Contacts move only on command, so enable stays closed for a run
    // A restart needs a fresh closure from the bench
    always @(negedge clk) begin
        if (target !== settledReg) begin
            maskReg    <= target ^ settledReg;
            settledReg <= target;
            cntReg     <= 2'h3;
        end else if (cntReg != 2'h0) begin
            cntReg <= cntReg - 2'h1;
        end
    end

    // Second cycle after a change falls back: a real contact bounces
    assign digitalInputs = settledReg ^ ((cntReg == 2'h2) ? maskReg : 9'h000);

    initial settledReg = 9'h000;
    initial maskReg = 9'h000;
    initial cntReg = 2'h0;
endmodule
`default_nettype wire

// ===== tb/test_run_command_and_ref_select.sv
// Testbench for the run command and reference select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin failCount++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module test_run_command_and_ref_select;
    import rcrs_pkg::*;
    logic clk = 0, rst = 1, runKey = 0, stopResetKey = 0, commStart = 0;
    logic commStop = 0, commReverse = 0, otherStop = 0, runIndicator;
    logic [1:0] runSourceSelect = 0, terminalModeSelect = 0;
    logic [2:0] referenceCombineMode = 0;
    logic [62:0] inputFunctionSelect = {FN_JOG_FWD, FN_RESET_FLT, FN_COAST, FN_SWAP_AB,
        FN_DOWN, FN_UP, FN_THREE_EN, FN_REVERSE, FN_FORWARD};
    logic [8:0] tgt = 0, digitalInputs;
    logic signed [15:0] channelA = 0, channelB = 0, effectiveReference, ex;
    logic [15:0] upRateSetting = 0, downRateSetting = 0;
    rcrs_cmd_type runCommand;
    logic [17:0] expQ[$];
    logic [17:0] e;
    int failCount = 0, testsRun = 0, seed = 21;
    event smp;

    rcrs_top #(.DEB_TICKS(2)) uut (.*);
    rcrs_partner contacts (.clk(clk), .target(tgt), .digitalInputs(digitalInputs));

    always #4 clk = ~clk;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic step(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic note(logic [1:0] s, logic [15:0] v);
        expQ.push_back({s, v});
        ->smp;
    endtask
    // Fixed wait covers sync, debounce and one bounce
    task automatic term(logic [8:0] t, int n = 12);
        tgt <= t;
        step(n);
    endtask
    task automatic done(string n);
        $display("test %s done", n);
    endtask
    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Monitor drains every queued note, oldest first, whenever a result is flagged
    always @(smp) begin
        while (expQ.size() > 0) begin
            e = expQ.pop_front();
            case (e[17:16])
                2'h0: `CHK({runIndicator, runCommand}, {e[1], e[1:0], e[5:2]})
                2'h1: `CHK(effectiveReference, e[15:0])
                default: `CHK(e[16] ? effectiveReference < channelA
                                    : effectiveReference > channelA, 1'b1)
            endcase
        end
    end

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        failCount++;
        printVerdict();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        step(12);
        rst = 0;
        step(2);
        note(0, 16'h0000);
        note(1, 16'h0000);
        runKey = 1; step(1); runKey = 0; step(1);
        note(0, 16'h0002);
        stopResetKey = 1; step(1); note(0, 16'h0000); step(1);
        note(0, 16'h0000);
        runKey = 1; stopResetKey = 1; step(1); runKey = 0; stopResetKey = 0; step(1);
        note(0, 16'h0002);
        stopResetKey = 1; step(1); stopResetKey = 0; step(1);
        done("keypad");
        runSourceSelect = SRC_COMM;
        for (int r = 0; r < 2; r++) begin
            commReverse = r[0]; commStart = 1; step(2);
            note(0, {15'h0001, r[0]});
            commStart = 0; commStop = 1; step(2);
            note(0, {15'h0000, r[0]});
            commStop = 0;
        end
        done("comm");
        runSourceSelect = SRC_TERMINAL;
        for (int m = 0; m < 2; m++) begin
            terminalModeSelect = m[1:0];
            for (int i = 4; i >= 0; i--) begin
                term({7'h00, 10'h078 >> (i * 2)});
                note(0, ((m == 0 ? 10'h1AD : 10'h0B5) >> (i * 2) & 16'h0003)
                        | (i == 0 ? 16'h0008 : 16'h0000));
            end
        end
        terminalModeSelect = TM_TWO_ONE;
        term(9'h001); note(0, 16'h0002);
        otherStop = 1; step(2); otherStop = 0; step(6);
        note(0, 16'h0000);
        term(9'h000); term(9'h001); note(0, 16'h0002);
        term(9'h000);
        done("two wire");
        terminalModeSelect = TM_THREE_ONE;
        term(9'h004); note(0, 16'h0000);
        term(9'h005); note(0, 16'h0002);
        term(9'h007); note(0, 16'h0003);
        term(9'h005); note(0, 16'h0002);
        term(9'h001); note(0, 16'h0000);
        terminalModeSelect = TM_THREE_TWO;
        term(9'h004); term(9'h005); note(0, 16'h0002);
        term(9'h007); note(0, 16'h0003);
        term(9'h003); note(0, 16'h0001);
        term(9'h180); note(0, 16'h0025);
        term(9'h000);
        done("three wire");
        for (int m = 0; m < 6; m++) begin
            channelA = $random(seed) % 2048;
            channelB = $random(seed) % 2048;
            referenceCombineMode = m[2:0];
            case (m)
                0: ex = channelA;
                1: ex = channelB;
                2: ex = channelA + channelB;
                3: ex = channelA - channelB;
                4: ex = channelA > channelB ? channelA : channelB;
                default: ex = channelA < channelB ? channelA : channelB;
            endcase
            step(3);
            note(1, ex);
        end
        referenceCombineMode = CM_A;
        term(9'h020); note(1, channelB);
        referenceCombineMode = CM_SUM;
        inputFunctionSelect[41:35] = FN_COMB_TO_A; step(4); note(1, channelA);
        inputFunctionSelect[41:35] = FN_COMB_TO_B; step(4); note(1, channelB);
        term(9'h000);
        referenceCombineMode = CM_A;
        upRateSetting = 16'h0003;
        term(9'h008, 20); term(9'h000); note(2, 16'h0000);
        downRateSetting = 16'h0005;
        term(9'h010, 40); term(9'h000); note(3, 16'h0000);
        done("reference");
        printVerdict();
    end
endmodule
bind rcrs_top rcrs_chk chk (.*);
`default_nettype wire
